// ### src/rpha_top.v
// Summary of operation
// - write strobe low with select takes data
// - out-of-range supply ignores all accesses
// - host reaches only the user copy
// - copying to user copy can pause
// - internal copy always counts with oscillator
// - seven calendar counters advance together
// - month ends and leap February handled
// - power fail deselects until supply recovers
// - alarm, watchdog, kick drive irq/reset
// - kick or alarm asserts power control
// - host software can release power control
// - reset held through failure plus recovery
// - read mode: select, enable low, strobe high
// - drivers on only with select and enable
// - read data follows address
// - write mode begins at later falling edge
// - copy bit 0 halts, 1 resumes, loads
// - bcd contents, 24-hour hours
`timescale 1ns/10ps
`default_nettype none
`include "rpha_defines.vh"
module rpha_top #(
	parameter OSC_DIV = `RPHA_OSC_DIV,
	parameter REC_CYCLES = `RPHA_REC_TIME_MS * `RPHA_CLK_MHZ * 1000
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// host byte bus
	input wire chip_sel_n,
	input wire out_en_n,
	input wire write_en_n,
	input wire [4:0] address_bus,
	input wire [7:0] data_bus_in,
	output reg [7:0] data_bus_out,
	output reg data_bus_oe,
	// supply and oscillator
	input wire supply_ok,
	input wire osc_tick,
	// wake and system control
	input wire wake_input_n,
	output reg irq_n,
	output reg supply_wake_n,
	output reg reset_out_n
);
	localparam integer REC_LAST_I = REC_CYCLES - 1; // full-width count, cut to the timer below
	localparam [23:0] REC_LAST = REC_LAST_I[23:0];
	// write tracker states
	localparam [2:0] WS_IDLE = 3'b001;
	localparam [2:0] WS_ACT = 3'b010;
	localparam [2:0] WS_DONE = 3'b100;

	reg [7:0] usr_ff [0:6]; // user-visible clock copy
	reg [7:0] asec_ff; // alarm seconds
	reg [7:0] amin_ff; // alarm minutes
	reg [7:0] ahour_ff; // alarm hours
	reg [7:0] wdog_ff; // watchdog period, seconds, 0 is off
	reg [7:0] wd_cnt_ff; // watchdog countdown
	reg [7:0] ctrl_ff; // control bits
	reg alarm_flag_ff;
	reg wd_flag_ff;
	reg kick_flag_ff;
	reg pwr_ff; // power-control hold
	reg wake_in_ff; // previous kick level
	reg load_ff; // calendar load pulse
	reg [2:0] ws_ff; // write tracker
	reg [4:0] wr_addr_ff; // address held at write start
	reg [7:0] wr_data_ff; // last data seen during write
	reg [23:0] rec_cnt_ff; // supply recovery timer
	reg rec_busy_ff;
	reg [2:0] nxt_ws;
	reg [7:0] nxt_rd;
	integer i;

	wire [7:0] int_sec, int_min, int_hour, int_wday, int_date, int_month, int_year;
	wire sec_pulse;
	wire wr_act; // write mode right now
	wire wr_commit; // end of an accepted write
	wire alarm_evt;
	wire kick_evt;
	wire wd_evt;

	// address decode shared by the read and write paths
	function is_time;
		input [4:0] a;
		begin
			is_time = (a <= `RPHA_ADR_YEAR);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// internal counting copy
	// host never touches this copy
	rpha_calendar #(.OSC_DIV(OSC_DIV)) u_cal (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.osc_tick(osc_tick),
		.load_en(load_ff),
		.ld_sec(usr_ff[0]),
		.ld_min(usr_ff[1]),
		.ld_hour(usr_ff[2]),
		.ld_wday(usr_ff[3]),
		.ld_date(usr_ff[4]),
		.ld_month(usr_ff[5]),
		.ld_year(usr_ff[6]),
		.sec_ff(int_sec),
		.min_ff(int_min),
		.hour_ff(int_hour),
		.wday_ff(int_wday),
		.date_ff(int_date),
		.month_ff(int_month),
		.year_ff(int_year),
		.sec_pulse_ff(sec_pulse)
	);

	////////////////////////////////////////////////////////////////////////////////
	// write mode detection
	// select and strobe both low
	// supply out of range blocks it
	assign wr_act = !chip_sel_n & !write_en_n & supply_ok;
	assign wr_commit = (ws_ff == WS_DONE);

	// tracker: idle, active write, one-cycle commit
	always @* begin
		nxt_ws = ws_ff;
		case (ws_ff)
			WS_IDLE: begin
				if (wr_act) begin
					nxt_ws = WS_ACT;
				end
			end
			WS_ACT: begin
				if (!supply_ok) begin
					nxt_ws = WS_IDLE;
				end else if (!wr_act) begin
					nxt_ws = WS_DONE;
				end
			end
			WS_DONE: begin
				nxt_ws = wr_act ? WS_ACT : WS_IDLE;
			end
			default: begin
				nxt_ws = WS_IDLE;
			end
		endcase
	end

	// address is fixed at the start, data tracked to the end
	always @(posedge sys_clk) begin
		if (!nrst) begin
			ws_ff <= WS_IDLE;
			wr_addr_ff <= 5'h00;
			wr_data_ff <= 8'h00;
		end else begin
			ws_ff <= nxt_ws;
			if (wr_act & (ws_ff != WS_ACT)) begin
				wr_addr_ff <= address_bus;
			end
			if (wr_act) begin
				wr_data_ff <= data_bus_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// event sources
	// alarm matches internal time of day
	assign alarm_evt = sec_pulse & (int_sec == asec_ff) & (int_min == amin_ff)
		& (int_hour == ahour_ff);
	assign kick_evt = wake_in_ff & !wake_input_n;
	assign wd_evt = sec_pulse & (wdog_ff != 8'h00) & (wd_cnt_ff == 8'h01);

	////////////////////////////////////////////////////////////////////////////////
	// user copy, alarm, watchdog and control registers
	always @(posedge sys_clk) begin
		if (!nrst) begin
			for (i = 0; i < 7; i = i + 1) begin
				usr_ff[i] <= `RPHA_RST_ZERO;
			end
			usr_ff[3] <= `RPHA_RST_DATE;
			usr_ff[4] <= `RPHA_RST_DATE;
			usr_ff[5] <= `RPHA_RST_MONTH;
			asec_ff <= `RPHA_RST_ZERO;
			amin_ff <= `RPHA_RST_ZERO;
			ahour_ff <= `RPHA_RST_ZERO;
			wdog_ff <= `RPHA_RST_ZERO;
			wd_cnt_ff <= `RPHA_RST_ZERO;
			ctrl_ff <= `RPHA_RST_CTRL;
			load_ff <= 1'b0;
		end else begin
			load_ff <= wr_commit & (wr_addr_ff == `RPHA_ADR_CTRL)
				& wr_data_ff[`RPHA_CTL_COPY] & !ctrl_ff[`RPHA_CTL_COPY];
			if (ctrl_ff[`RPHA_CTL_COPY] & !load_ff) begin
				usr_ff[0] <= int_sec;
				usr_ff[1] <= int_min;
				usr_ff[2] <= int_hour;
				usr_ff[3] <= int_wday;
				usr_ff[4] <= int_date;
				usr_ff[5] <= int_month;
				usr_ff[6] <= int_year;
			end
			if (wr_commit & is_time(wr_addr_ff)) begin
				usr_ff[wr_addr_ff[2:0]] <= wr_data_ff;
			end
			// watchdog countdown, reloaded by a write
			if (wr_commit & (wr_addr_ff == `RPHA_ADR_WDOG)) begin
				wdog_ff <= wr_data_ff;
				wd_cnt_ff <= wr_data_ff;
			end else if (sec_pulse & (wdog_ff != 8'h00)) begin
				wd_cnt_ff <= (wd_cnt_ff == 8'h01) ? wdog_ff : wd_cnt_ff - 8'h01;
			end
			if (wr_commit) begin
				if (wr_addr_ff == `RPHA_ADR_ASEC) begin
					asec_ff <= wr_data_ff;
				end else if (wr_addr_ff == `RPHA_ADR_AMIN) begin
					amin_ff <= wr_data_ff;
				end else if (wr_addr_ff == `RPHA_ADR_AHOUR) begin
					ahour_ff <= wr_data_ff;
				end else if (wr_addr_ff == `RPHA_ADR_CTRL) begin
					ctrl_ff <= wr_data_ff;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky flags and power-control hold; a set beats a clear in the same cycle
	always @(posedge sys_clk) begin
		if (!nrst) begin
			alarm_flag_ff <= 1'b0;
			wd_flag_ff <= 1'b0;
			kick_flag_ff <= 1'b0;
			pwr_ff <= 1'b0;
			wake_in_ff <= 1'b1;
		end else begin
			wake_in_ff <= wake_input_n;
			// writing ones to the flag byte clears them
			if (wr_commit & (wr_addr_ff == `RPHA_ADR_FLAG)) begin
				alarm_flag_ff <= alarm_flag_ff & !wr_data_ff[`RPHA_FLG_ALARM];
				wd_flag_ff <= wd_flag_ff & !wr_data_ff[`RPHA_FLG_WD];
				kick_flag_ff <= kick_flag_ff & !wr_data_ff[`RPHA_FLG_KICK];
			end
			if (alarm_evt) begin
				alarm_flag_ff <= 1'b1;
			end
			if (wd_evt) begin
				wd_flag_ff <= 1'b1;
			end
			if (kick_evt) begin
				kick_flag_ff <= 1'b1;
			end
			// software sets or releases the hold
			if (wr_commit & (wr_addr_ff == `RPHA_ADR_CTRL)) begin
				pwr_ff <= wr_data_ff[`RPHA_CTL_PWR_HOLD];
			end
			// kick or wake alarm turns power on
			if (kick_evt | (alarm_evt & ctrl_ff[`RPHA_CTL_WAKE_EN])) begin
				pwr_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// supply recovery timer; nrst counts as a power-on
	always @(posedge sys_clk) begin
		if (!nrst) begin
			rec_cnt_ff <= 24'h000000;
			rec_busy_ff <= 1'b1;
		end else if (!supply_ok) begin
			// restart while the supply is bad
			rec_cnt_ff <= 24'h000000;
			rec_busy_ff <= 1'b1;
		end else if (rec_busy_ff) begin
			if (rec_cnt_ff == REC_LAST) begin
				rec_busy_ff <= 1'b0;
			end else begin
				rec_cnt_ff <= rec_cnt_ff + 24'h000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read multiplexer; flags and control read back live state
	always @* begin
		nxt_rd = 8'h00;
		if (is_time(address_bus)) begin
			nxt_rd = usr_ff[address_bus[2:0]];
		end else if (address_bus == `RPHA_ADR_ASEC) begin
			nxt_rd = asec_ff;
		end else if (address_bus == `RPHA_ADR_AMIN) begin
			nxt_rd = amin_ff;
		end else if (address_bus == `RPHA_ADR_AHOUR) begin
			nxt_rd = ahour_ff;
		end else if (address_bus == `RPHA_ADR_WDOG) begin
			nxt_rd = wdog_ff;
		end else if (address_bus == `RPHA_ADR_CTRL) begin
			nxt_rd = ctrl_ff;
			nxt_rd[`RPHA_CTL_PWR_HOLD] = pwr_ff;
		end else if (address_bus == `RPHA_ADR_FLAG) begin
			nxt_rd[`RPHA_FLG_ALARM] = alarm_flag_ff;
			nxt_rd[`RPHA_FLG_WD] = wd_flag_ff;
			nxt_rd[`RPHA_FLG_KICK] = kick_flag_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered pins
	always @(posedge sys_clk) begin
		if (!nrst) begin
			data_bus_out <= 8'h00;
			data_bus_oe <= 1'b0;
			irq_n <= 1'b1;
			supply_wake_n <= 1'b1;
			reset_out_n <= 1'b0;
		end else begin
			// data follows the address each cycle
			data_bus_out <= nxt_rd;
			// drive only with select and enable
			data_bus_oe <= supply_ok & !chip_sel_n & !out_en_n & write_en_n;
			irq_n <= !((alarm_flag_ff & ctrl_ff[`RPHA_CTL_ALARM_IE])
				| (kick_flag_ff & ctrl_ff[`RPHA_CTL_KICK_IE])
				| (wd_flag_ff & ctrl_ff[`RPHA_CTL_WD_IE] & !ctrl_ff[`RPHA_CTL_WD_RST]));
			supply_wake_n <= !pwr_ff;
			reset_out_n <= !(rec_busy_ff | !supply_ok
				| (wd_flag_ff & ctrl_ff[`RPHA_CTL_WD_RST]));
		end
	end
endmodule
`default_nettype wire

// ### src/rpha_defines.vh
`ifndef RPHA_DEFINES_VH
`define RPHA_DEFINES_VH
// byte addresses of the host-visible locations
`define RPHA_ADR_SEC 5'h00
`define RPHA_ADR_MIN 5'h01
`define RPHA_ADR_HOUR 5'h02
`define RPHA_ADR_WDAY 5'h03
`define RPHA_ADR_DATE 5'h04
`define RPHA_ADR_MONTH 5'h05
`define RPHA_ADR_YEAR 5'h06
`define RPHA_ADR_ASEC 5'h07
`define RPHA_ADR_AMIN 5'h08
`define RPHA_ADR_AHOUR 5'h09
`define RPHA_ADR_WDOG 5'h0a
`define RPHA_ADR_CTRL 5'h0b
`define RPHA_ADR_FLAG 5'h0c
// control register fields
`define RPHA_CTL_ALARM_IE 0
`define RPHA_CTL_WD_RST 1
`define RPHA_CTL_WAKE_EN 2
`define RPHA_CTL_PWR_HOLD 3
`define RPHA_CTL_KICK_IE 4
`define RPHA_CTL_WD_IE 5
`define RPHA_CTL_COPY 7
// flag register fields
`define RPHA_FLG_ALARM 0
`define RPHA_FLG_WD 1
`define RPHA_FLG_KICK 2
// reset values
`define RPHA_RST_CTRL 8'h80
`define RPHA_RST_DATE 8'h01
`define RPHA_RST_MONTH 8'h01
`define RPHA_RST_ZERO 8'h00
// timing
`define RPHA_CLK_MHZ 100
`define RPHA_REC_TIME_MS 150
`define RPHA_OSC_DIV 32768
`endif

// ### src/rpha_calendar.v
`timescale 1ns/10ps
`default_nettype none
`include "rpha_defines.vh"
module rpha_calendar #(
	parameter OSC_DIV = `RPHA_OSC_DIV
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// oscillator tick, one pulse per oscillator period
	input wire osc_tick,
	// load from the user-visible copy
	input wire load_en,
	input wire [7:0] ld_sec,
	input wire [7:0] ld_min,
	input wire [7:0] ld_hour,
	input wire [7:0] ld_wday,
	input wire [7:0] ld_date,
	input wire [7:0] ld_month,
	input wire [7:0] ld_year,
	// internal counting copy
	output reg [7:0] sec_ff,
	output reg [7:0] min_ff,
	output reg [7:0] hour_ff,
	output reg [7:0] wday_ff,
	output reg [7:0] date_ff,
	output reg [7:0] month_ff,
	output reg [7:0] year_ff,
	output reg sec_pulse_ff
);
	localparam integer DIV_LAST_I = OSC_DIV - 1; // full-width count, cut to the prescaler below
	localparam [15:0] DIV_LAST = DIV_LAST_I[15:0];
	reg [15:0] div_ff; // oscillator prescaler

	// bcd increment of one byte
	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9) begin
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			end else begin
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
			end
		end
	endfunction

	// two-digit bcd year divisible by four; year 00 counts as leap
	function leap_year;
		input [7:0] y;
		begin
			if (y[4] == 1'b0) begin
				leap_year = (y[3:0] == 4'h0) | (y[3:0] == 4'h4) | (y[3:0] == 4'h8);
			end else begin
				leap_year = (y[3:0] == 4'h2) | (y[3:0] == 4'h6);
			end
		end
	endfunction

	// last date of the month in bcd
	function [7:0] month_last;
		input [7:0] m;
		input [7:0] y;
		begin
			case (m)
				8'h02: month_last = leap_year(y) ? 8'h29 : 8'h28;
				8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
				default: month_last = 8'h31;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// prescaler and calendar chain, all fields advance in one edge
	always @(posedge sys_clk) begin
		sec_pulse_ff <= 1'b0;
		if (!nrst) begin
			div_ff <= 16'h0000;
			sec_ff <= `RPHA_RST_ZERO;
			min_ff <= `RPHA_RST_ZERO;
			hour_ff <= `RPHA_RST_ZERO;
			wday_ff <= `RPHA_RST_DATE;
			date_ff <= `RPHA_RST_DATE;
			month_ff <= `RPHA_RST_MONTH;
			year_ff <= `RPHA_RST_ZERO;
		end else if (load_en) begin
			div_ff <= 16'h0000;
			sec_ff <= ld_sec;
			min_ff <= ld_min;
			hour_ff <= ld_hour;
			wday_ff <= ld_wday;
			date_ff <= ld_date;
			month_ff <= ld_month;
			year_ff <= ld_year;
		end else if (osc_tick) begin
			if (div_ff != DIV_LAST) begin
				div_ff <= div_ff + 16'h0001;
			end else begin
				div_ff <= 16'h0000;
				sec_pulse_ff <= 1'b1;
				if (sec_ff != 8'h59) begin
					sec_ff <= bcd_inc(sec_ff);
				end else begin
					sec_ff <= 8'h00;
					if (min_ff != 8'h59) begin
						min_ff <= bcd_inc(min_ff);
					end else begin
						min_ff <= 8'h00;
						if (hour_ff != 8'h23) begin
							hour_ff <= bcd_inc(hour_ff);
						end else begin
							hour_ff <= 8'h00;
							// weekday wraps 7 to 1 at midnight
							wday_ff <= (wday_ff == 8'h07) ? 8'h01 : bcd_inc(wday_ff);
							if (date_ff != month_last(month_ff, year_ff)) begin
								date_ff <= bcd_inc(date_ff);
							end else begin
								date_ff <= 8'h01;
								if (month_ff != 8'h12) begin
									month_ff <= bcd_inc(month_ff);
								end else begin
									month_ff <= 8'h01;
									year_ff <= (year_ff == 8'h99) ? 8'h00 : bcd_inc(year_ff);
								end
							end
						end
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### src/unused_placeholder_none.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### sim/rpha_top_checker.sv
`timescale 1ns/10ps
`default_nettype none
module rpha_top_checker #(
	parameter int REC_CYCLES = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// host strobes
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	// supply and wake
	input wire logic supply_ok,
	input wire logic wake_input_n,
	// device outputs
	input wire logic data_bus_oe,
	input wire logic irq_n,
	input wire logic supply_wake_n,
	input wire logic reset_out_n
);
	// cycles of good supply since reset or the last dropout, saturating
	int rec_cnt_ff;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////////
	// recovery counter, small saturation keeps it cheap
	always_ff @(posedge sys_clk) begin
		if (!nrst || !supply_ok) begin
			rec_cnt_ff <= 0;
		end else if (rec_cnt_ff < REC_CYCLES + 2) begin
			rec_cnt_ff <= rec_cnt_ff + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	reset_vals_a: assert property ($rose(nrst) |-> !reset_out_n && !data_bus_oe && irq_n && supply_wake_n)
		else $error("outputs not at reset level after reset");
	read_mode_a: assert property (supply_ok && !chip_sel_n && !out_en_n && write_en_n |=> data_bus_oe)
		else $error("read mode did not enable the drivers");
	drive_cause_a: assert property (data_bus_oe |-> $past(!chip_sel_n && !out_en_n))
		else $error("drivers on without select and enable");
	desel_hiz_a: assert property (chip_sel_n |=> !data_bus_oe)
		else $error("deselected device drives the bus");
	write_hiz_a: assert property (!chip_sel_n && !write_en_n |=> !data_bus_oe)
		else $error("bus driven during write mode");
	supply_block_a: assert property (!supply_ok |=> !data_bus_oe)
		else $error("bus driven with supply out of range");
	rst_hold_a: assert property (!supply_ok |=> !reset_out_n)
		else $error("reset output released during supply fault");
	rec_time_a: assert property (reset_out_n |-> rec_cnt_ff >= REC_CYCLES - 1)
		else $error("reset output released before recovery time");
	kick_pwr_a: assert property ($fell(wake_input_n) |-> ##[1:3] !supply_wake_n)
		else $error("wake input did not assert power control");
endmodule

bind rpha_top rpha_top_checker #(.REC_CYCLES(REC_CYCLES)) rpha_top_checker_inst (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.chip_sel_n(chip_sel_n),
	.out_en_n(out_en_n),
	.write_en_n(write_en_n),
	.supply_ok(supply_ok),
	.wake_input_n(wake_input_n),
	.data_bus_oe(data_bus_oe),
	.irq_n(irq_n),
	.supply_wake_n(supply_wake_n),
	.reset_out_n(reset_out_n)
);
`default_nettype wire

// ### sim/rpha_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rpha_host_model (
	// clock
	input wire logic sys_clk,
	// bus toward the device
	output logic chip_sel_n,
	output logic out_en_n,
	output logic write_en_n,
	output logic [4:0] address_bus,
	output logic [7:0] host_data,
	// answer from the device
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe
);
	// idle bus, all strobes inactive
	initial begin
		chip_sel_n = 1'b1;
		out_en_n = 1'b1;
		write_en_n = 1'b1;
		address_bus = 5'h00;
		host_data = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// write cycle
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		chip_sel_n = 1'b0;
		write_en_n = 1'b0;
		address_bus = a;
		host_data = d;
		repeat (2) @(posedge sys_clk);
		#1;
		chip_sel_n = 1'b1;
		write_en_n = 1'b1;
		// released bus shows the inverse so a stale byte cannot match
		host_data = ~d;
		repeat (2) @(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// read cycle, second address taken without leaving read mode
	task automatic rd2(input logic [4:0] a1, input logic [4:0] a2, output logic [7:0] d1,
			output logic [7:0] d2, output logic oe);
		@(posedge sys_clk);
		#1;
		chip_sel_n = 1'b0;
		out_en_n = 1'b0;
		address_bus = a1;
		repeat (2) @(posedge sys_clk);
		#1;
		d1 = data_bus_out;
		oe = data_bus_oe;
		address_bus = a2;
		repeat (2) @(posedge sys_clk);
		#1;
		d2 = data_bus_out;
		chip_sel_n = 1'b1;
		out_en_n = 1'b1;
		// park the address away from the last location
		address_bus = ~a2;
		@(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ### sim/tb_rpha_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rpha_top;
	localparam int REC = 8;
	// design side
	logic sys_clk, nrst, supply_ok, osc_tick, wake_input_n;
	logic chip_sel_n, out_en_n, write_en_n, data_bus_oe, irq_n, supply_wake_n, reset_out_n;
	logic [4:0] address_bus;
	logic [7:0] host_data, data_bus_in, data_bus_out;
	// bench state: rows are {write, address, data, expected}
	int errors, checks, cycles;
	logic [21:0] rows [0:11];
	logic [7:0] d1, d2, yr;
	logic [7:0] exp_t [0:6];
	logic oe;

	// wire level of the shared data bus
	assign data_bus_in = data_bus_oe ? data_bus_out : host_data;

	rpha_top #(.OSC_DIV(4), .REC_CYCLES(REC)) rpha_top_inst (
		.sys_clk(sys_clk), .nrst(nrst), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.write_en_n(write_en_n), .address_bus(address_bus), .data_bus_in(data_bus_in),
		.data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .supply_ok(supply_ok),
		.osc_tick(osc_tick), .wake_input_n(wake_input_n), .irq_n(irq_n),
		.supply_wake_n(supply_wake_n), .reset_out_n(reset_out_n));
	rpha_host_model rpha_host_model_inst (
		.sys_clk(sys_clk), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.write_en_n(write_en_n), .address_bus(address_bus), .host_data(host_data),
		.data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic cmp(input logic [7:0] got, input logic [7:0] want);
		checks++;
		if (got !== want) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] want);
		rpha_host_model_inst.rd2(a, a, d1, d2, oe);
		cmp(d1, want);
		cmp({7'h00, oe}, 8'h01);
	endtask
	// whole seconds of oscillator pulses, four per second in this build
	task automatic ticks(input int n);
		repeat (n * 4) begin
			@(posedge sys_clk) #1 osc_tick = 1'b1;
			@(posedge sys_clk) #1 osc_tick = 1'b0;
		end
		repeat (3) @(posedge sys_clk);
		// step off the edge so outputs are looked at once settled
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		supply_ok = 1'b1;
		osc_tick = 1'b0;
		wake_input_n = 1'b1;
		errors = 0;
		checks = 0;
		cycles = 0;
		rows = '{{1'b0, 5'h0b, 8'h00, 8'h80}, {1'b0, 5'h04, 8'h00, 8'h01},
			{1'b0, 5'h05, 8'h00, 8'h01}, {1'b0, 5'h03, 8'h00, 8'h01},
			{1'b0, 5'h06, 8'h00, 8'h00}, {1'b0, 5'h00, 8'h00, 8'h00},
			{1'b0, 5'h0c, 8'h00, 8'h00}, {1'b0, 5'h1f, 8'h00, 8'h00},
			{1'b1, 5'h0b, 8'h00, 8'h00}, {1'b1, 5'h1f, 8'h55, 8'h00},
			{1'b1, 5'h07, 8'h12, 8'h12}, {1'b1, 5'h0a, 8'h00, 8'h00}};
		repeat (2) @(posedge sys_clk);
		#1 nrst = 1'b1;
		// reset contents, unmapped space, plain write and read back
		for (int i = 0; i < 12; i++) begin
			if (rows[i][21]) rpha_host_model_inst.wr(rows[i][20:16], rows[i][15:8]);
			rd_chk(rows[i][20:16], rows[i][7:0]);
		end
		// last second of february 28, plain year then leap year
		for (int y = 0; y < 2; y++) begin
			yr = y ? 8'h24 : 8'h23;
			exp_t = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, yr};
			rpha_host_model_inst.wr(5'h0b, 8'h00);
			for (int i = 0; i < 7; i++) rpha_host_model_inst.wr(i[4:0], exp_t[i]);
			rpha_host_model_inst.wr(5'h0b, 8'h80);
			ticks(1);
			exp_t = '{8'h00, 8'h00, 8'h00, 8'h01, y ? 8'h29 : 8'h01, y ? 8'h02 : 8'h03, yr};
			for (int i = 0; i < 7; i++) rd_chk(i[4:0], exp_t[i]);
		end
		// frozen user copy while the internal copy reaches the alarm
		rpha_host_model_inst.wr(5'h07, 8'h02);
		rpha_host_model_inst.wr(5'h0b, 8'h01);
		ticks(3);
		cmp({7'h00, irq_n}, 8'h00);
		rd_chk(5'h00, 8'h00);
		rpha_host_model_inst.wr(5'h0c, 8'h01);
		// irq_n is registered behind the flag, so it rises one edge after the clear
		repeat (2) @(posedge sys_clk);
		#1 cmp({7'h00, irq_n}, 8'h01);
		// wake event raises power control, software drops it
		@(posedge sys_clk) #1 wake_input_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 cmp({7'h00, supply_wake_n}, 8'h00);
		wake_input_n = 1'b1;
		rd_chk(5'h0b, 8'h09);
		rpha_host_model_inst.wr(5'h0b, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1 cmp({7'h00, supply_wake_n}, 8'h01);
		// address change inside one read
		rpha_host_model_inst.rd2(5'h07, 5'h0b, d1, d2, oe);
		cmp(d1, 8'h02);
		cmp(d2, 8'h01);
		// supply dropout: no access, reset held through recovery
		@(posedge sys_clk) #1 supply_ok = 1'b0;
		rpha_host_model_inst.wr(5'h08, 8'h33);
		rpha_host_model_inst.rd2(5'h08, 5'h08, d1, d2, oe);
		cmp({7'h00, oe}, 8'h00);
		cmp({7'h00, reset_out_n}, 8'h00);
		@(posedge sys_clk) #1 supply_ok = 1'b1;
		repeat (REC + 4) @(posedge sys_clk);
		#1 cmp({7'h00, reset_out_n}, 8'h01);
		rd_chk(5'h08, 8'h00);
		// mid-run reset brings back reset output and reset contents
		@(posedge sys_clk) #1 nrst = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 nrst = 1'b1;
		cmp({7'h00, reset_out_n}, 8'h00);
		rd_chk(5'h0b, 8'h80);
		give_verdict();
	end
endmodule
`default_nettype wire
